//--- hw/vtc_fifo.sv
`default_nettype none
// ********************************************************************
// small request fifo
// ********************************************************************
module vtc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage flops
        logic [AW-1:0]               wr;    // write index
        logic [AW-1:0]               rd;    // read index
        logic [AW:0]                 cnt;   // fill level
    } vtc_fifo_s;
    vtc_fifo_s st_q, st_d;
    logic push, pop;

    // handshakes from the fill level
    assign o_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign o_valid = (st_q.cnt != '0);
    assign o_data  = st_q.mem[st_q.rd];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // next state
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = i_data;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // vtc_fifo
`default_nettype wire

//--- hw/vtc_pkg.sv
`default_nettype none
package vtc_pkg;

    // ****************************************************************
    // timing of the transfer cycle, in clock cycles at 40 MHz
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 25;    // system clock period
    localparam int unsigned SETUP_NS         = 25;    // strobe and address lead before row strobe
    localparam int unsigned ROW_HOLD_NS      = 50;    // row address hold after row strobe
    localparam int unsigned COL_HOLD_NS      = 75;    // column strobe low time
    localparam int unsigned SHIFT_CLOCK_PHASE_LOW_NS      = 40;    // optional shift clock low pulse
    localparam int unsigned GAP_NS           = 90;    // pulse end to first pixel byte strobe
    // least times round up
    localparam int unsigned SETUP_CYC    = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COL_CYC      = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned VLOW_CYC     = (SHIFT_CLOCK_PHASE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC      = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int unsigned ROW_W  = 8;   // row / start address width
    localparam int unsigned BANK_W = 2;   // bank select bits
    localparam int unsigned CTL_W  = 3;   // serializer control bits
    localparam int unsigned WE_W   = 4;   // write enable lanes
    localparam int unsigned CNT_W  = 4;   // phase counter width
    localparam int unsigned FIFO_DEPTH = 4;

    // ****************************************************************
    // request word
    // ****************************************************************
    typedef struct packed {
        logic [BANK_W-1:0] bank;      // bank select address bits
        logic [ROW_W-1:0]  row;       // row address
        logic [ROW_W-1:0]  start;     // shifter start address
        logic [CTL_W-1:0]  offset;    // start offset control
        logic [CTL_W-1:0]  bitcount;  // bit count for first pixel byte strobe
        logic              pulse_en;  // produce the shift clock low pulse
    } vtc_req_s;
    localparam int unsigned REQ_W = $bits(vtc_req_s);

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_ROW   = 3'b010,
        ST_COL   = 3'b011,
        ST_REL   = 3'b100,
        ST_GAP   = 3'b101,
        ST_VLOW  = 3'b110,
        ST_PIX   = 3'b111
    } vtc_state_e;

    // memory-side pins
    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              xfg_n;     // transfer_gate_strobe, active low
        logic [WE_W-1:0]   we_n;
        logic [ROW_W-1:0]  addr;
        logic [BANK_W-1:0] bank;
    } vtc_mem_s;

endpackage
`default_nettype wire

//--- hw/vtc_transfer.sv
`default_nettype none
// ********************************************************************
// ********************************************************************
module vtc_transfer (
    // clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_reset,
    // transfer requests
    input  wire logic                        i_req_valid,
    output logic                             o_req_ready,
    input  wire vtc_pkg::vtc_req_s           i_req,
    // display side pixel byte strobe enable
    input  wire logic                        i_pix_tick,
    // memory pins
    output vtc_pkg::vtc_mem_s                o_mem,
    // serializer pins
    output logic [vtc_pkg::CTL_W-1:0]        o_serializer_control_bits,
    output logic                             o_shift_clock_phase,
    output logic                             o_pixel_byte_strobe,
    // status
    output logic                             o_busy
);
    // ****************************************************************
    // request fifo
    // ****************************************************************
    logic              f_valid;   // fifo has a request
    logic              f_take;    // sequencer accepts it
    vtc_pkg::vtc_req_s f_data;    // head of fifo

    vtc_fifo #(
        .WIDTH (vtc_pkg::REQ_W),
        .DEPTH (vtc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_valid   (i_req_valid),
        .o_ready   (o_req_ready),
        .i_data    (i_req),
        .o_valid   (f_valid),
        .i_ready   (f_take),
        .o_data    (f_data)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        vtc_pkg::vtc_state_e              state;   // sequencer state
        logic [vtc_pkg::CNT_W-1:0]        cnt;     // cycles left in state
        vtc_pkg::vtc_req_s                req;     // current request
        vtc_pkg::vtc_mem_s                mem;     // memory pins
        logic [vtc_pkg::CTL_W-1:0]        ctl;     // serializer control
        logic                             shift_clock_phase;    // shift clock phase
        logic                             pixel_byte_strobe;    // pixel byte strobe
        logic                             run;     // pixel strobing active
    } vtc_top_s;
    vtc_top_s st_q, st_d;

    assign f_take = (st_q.state == vtc_pkg::ST_IDLE) && f_valid;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.pixel_byte_strobe = 1'b0;
        st_d.mem.we_n = '1;
        if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        case (st_q.state)
            vtc_pkg::ST_IDLE: begin
                // pixel strobes keep running between transfers, a new transfer wins
                if (st_q.run && i_pix_tick && !f_valid) begin
                    st_d.pixel_byte_strobe = 1'b1;
                    st_d.shift_clock_phase = ~st_q.shift_clock_phase;
                end
                if (f_valid) begin
                    st_d.req = f_data;
                    st_d.run = 1'b0;
                    st_d.shift_clock_phase = 1'b1;
                    st_d.mem.addr = f_data.row;
                    st_d.mem.bank = f_data.bank;
                    st_d.mem.xfg_n = 1'b0;
                    st_d.ctl = f_data.offset;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::SETUP_CYC - 1);
                    st_d.state = vtc_pkg::ST_SETUP;
                end
            end
            vtc_pkg::ST_SETUP: begin
                // strobe and row already stand; now drop row strobe
                if (st_q.cnt == '0) begin
                    st_d.mem.ras_n = 1'b0;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::ROW_HOLD_CYC - 1);
                    st_d.state = vtc_pkg::ST_ROW;
                end
            end
            vtc_pkg::ST_ROW: begin
                // row held, then start address before column fall
                if (st_q.cnt == '0) begin
                    st_d.mem.addr = st_q.req.start;
                    st_d.state = vtc_pkg::ST_COL;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::COL_CYC);
                end
            end
            vtc_pkg::ST_COL: begin
                st_d.mem.cas_n = 1'b0;
                if (st_q.cnt == '0) begin
                    st_d.mem.xfg_n = 1'b1;
                    st_d.ctl = st_q.req.bitcount;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::SETUP_CYC - 1);
                    st_d.state = vtc_pkg::ST_REL;
                end
            end
            vtc_pkg::ST_REL: begin
                // strobe released one stage before both strobes rise
                if (st_q.cnt == '0) begin
                    st_d.mem.ras_n = 1'b1;
                    st_d.mem.cas_n = 1'b1;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::VLOW_CYC - 1);
                    if (st_q.req.pulse_en) begin
                        st_d.shift_clock_phase = 1'b0;
                        st_d.state = vtc_pkg::ST_VLOW;
                    end else begin
                        st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::GAP_CYC - 1);
                        st_d.state = vtc_pkg::ST_GAP;
                    end
                end
            end
            vtc_pkg::ST_VLOW: begin
                if (st_q.cnt == '0) begin
                    st_d.shift_clock_phase = 1'b1;
                    st_d.cnt = vtc_pkg::CNT_W'(vtc_pkg::GAP_CYC - 1);
                    st_d.state = vtc_pkg::ST_GAP;
                end
            end
            vtc_pkg::ST_GAP: begin
                if (st_q.cnt == '0) begin
                    st_d.state = vtc_pkg::ST_PIX;
                end
            end
            vtc_pkg::ST_PIX: begin
                // first possible pixel byte strobe, bit count stands
                st_d.pixel_byte_strobe = 1'b1;
                st_d.shift_clock_phase = ~st_q.shift_clock_phase;
                st_d.run = 1'b1;
                st_d.state = vtc_pkg::ST_IDLE;
            end
            default: begin
                st_d.state = vtc_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // register
    // ****************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_q <= '0;
            st_q.state <= vtc_pkg::ST_IDLE;
            st_q.mem.ras_n <= 1'b1;
            st_q.mem.cas_n <= 1'b1;
            st_q.mem.xfg_n <= 1'b1;
            st_q.mem.we_n <= '1;
            st_q.shift_clock_phase <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs from flops
    assign o_mem = st_q.mem;
    assign o_serializer_control_bits = st_q.ctl;
    assign o_shift_clock_phase = st_q.shift_clock_phase;
    assign o_pixel_byte_strobe = st_q.pixel_byte_strobe;
    assign o_busy = (st_q.state != vtc_pkg::ST_IDLE);

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_gate_before_row: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_mem.ras_n) |-> !o_mem.xfg_n && $past(!o_mem.xfg_n))
        else $error("gate strobe not active before row strobe fall");
    chk_gate_release: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $rose(o_mem.ras_n) |-> $past(o_mem.xfg_n))
        else $error("gate strobe still active at row strobe rise");
    chk_we_high: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !o_mem.ras_n |-> o_mem.we_n == '1)
        else $error("write enable low during transfer");
    chk_row_addr: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_mem.ras_n) |-> o_mem.addr == st_q.req.row)
        else $error("row address wrong at row strobe fall");
    chk_col_addr: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_mem.cas_n) |-> o_mem.addr == st_q.req.start)
        else $error("start address wrong at column fall");
    chk_offset_ctl: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_mem.ras_n) |-> o_serializer_control_bits == st_q.req.offset)
        else $error("start offset missing at row fall");
    chk_pulse_width: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_shift_clock_phase) && o_mem.xfg_n && st_q.state == vtc_pkg::ST_VLOW
        |-> !o_shift_clock_phase [*2] ##1 o_shift_clock_phase)
        else $error("shift clock low pulse width wrong");
    chk_shift_clock_phase_high_row: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_mem.ras_n) |-> o_shift_clock_phase)
        else $error("shift clock not high at transfer start");
    chk_toggle: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_pixel_byte_strobe |-> o_shift_clock_phase != $past(o_shift_clock_phase))
        else $error("shift clock did not toggle on pixel strobe");
    chk_bitcount: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $rose(o_mem.ras_n) |-> ##[1:8] o_pixel_byte_strobe
            && o_serializer_control_bits == st_q.req.bitcount)
        else $error("bit count not valid at first pixel strobe");
endmodule // vtc_transfer
`default_nettype wire

//--- test/vtc_transfer_test.sv
`default_nettype none
module vtc_transfer_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // signals
    // ****
    logic              i_clk_sys, i_reset, i_req_valid, o_req_ready, i_pix_tick;
    logic              shift_clock_phase, pstb, o_busy, load_pulse, active, saw_full;
    logic [2:0]        ctl, bcap;
    logic [1:0]        bank_q;
    logic [11:0]       offs;
    logic [3:0]        rclk, lclk, ren, len;
    int                err_count, tests_run, k, s;
    vtc_pkg::vtc_req_s i_req, cur;
    vtc_pkg::vtc_mem_s o_mem;
    vtc_pkg::vtc_req_s exp_q[$];  // accepted requests awaiting their transfer

    vtc_transfer DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid),
        .o_req_ready(o_req_ready), .i_req(i_req), .i_pix_tick(i_pix_tick), .o_mem(o_mem),
        .o_serializer_control_bits(ctl), .o_shift_clock_phase(shift_clock_phase),
        .o_pixel_byte_strobe(pstb), .o_busy(o_busy));
    vtc_vram_model u_far (.i_mem(o_mem), .i_ctl(ctl), .i_phase(shift_clock_phase), .i_strobe(pstb),
        .o_load_pulse(load_pulse), .o_bank_q(bank_q), .o_offset_cap(offs),
        .o_bitcount_cap(bcap), .o_right_clk(rclk), .o_left_clk(lclk), .o_right_en(ren),
        .o_left_en(len));

    // clock, 25 ns period
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // ****
    // compares and closing
    // ****
    task automatic cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_cap(input string nm, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // expected {row, column, gate, shift clock, byte strobe} at k cycles after gate fall
    function automatic logic [4:0] exp_pins(input vtc_pkg::vtc_req_s r, input int k);
        int s;
        s = r.pulse_en ? 15 : 13;
        exp_pins[4] = !(k >= 1 && k <= 7);
        exp_pins[3] = !(k >= 4 && k <= 7);
        exp_pins[2] = (k >= 7);
        exp_pins[1] = !((r.pulse_en && (k == 8 || k == 9)) || k >= s);
        exp_pins[0] = (k == s);
    endfunction
    function automatic vtc_pkg::vtc_req_s rnd_req();
        logic [31:0] v;
        v = $urandom;
        rnd_req = v[vtc_pkg::REQ_W-1:0];
    endfunction
    // ****
    // transfer monitor: every gate fall must match the oldest accepted request
    // ****
    always @(posedge i_clk_sys) begin
        #2;
        if (o_req_ready === 1'b0) saw_full = 1'b1;
        if (!i_reset && !active && o_mem.xfg_n === 1'b0) begin
            if (exp_q.size() == 0) cmp_pin("extra transfer", 8'h0, 8'h1);
            else begin
                cur = exp_q.pop_front();
                active = 1'b1;
                k = 0;
                s = cur.pulse_en ? 15 : 13;
            end
        end
        if (active) begin
            cmp_pin("pins", exp_pins(cur, k),
                {o_mem.ras_n, o_mem.cas_n, o_mem.xfg_n, shift_clock_phase, pstb});
            cmp_pin("we_n", 8'h0f, o_mem.we_n);
            if (k <= 7) cmp_pin("addr", (k < 3) ? cur.row : cur.start, o_mem.addr);
            cmp_pin("control", (k < 7) ? cur.offset : cur.bitcount, ctl);
            if (k == 3) cmp_pin("busy", 8'h1, o_busy);
            if (k == s - 1) begin
                cmp_cap("offsets", {4{cur.offset}}, offs);
                cmp_cap("bank", cur.bank, bank_q);
                cmp_cap("left enable", 4'h1 << cur.bank, len);
                cmp_cap("right clock", 4'h1 << cur.bank, rclk);
            end
            if (k == s) begin
                cmp_cap("bit count", cur.bitcount, bcap);
                cmp_cap("right enable", 4'h1 << cur.bank, ren);
                cmp_cap("left clock", 4'h1 << cur.bank, lclk);
                active = 1'b0;
            end
            k++;
        end
    end
    // ****
    // stimulus tasks
    // ****
    task automatic push(input vtc_pkg::vtc_req_s r);
        int n;
        n = 0;
        #1;
        i_req_valid = 1'b1;
        i_req = r;
        while (o_req_ready !== 1'b1 && n < 100) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        if (n == 100) begin
            cmp_pin("ready wait", 8'h1, 8'h0);
            tally_and_finish();
        end
        @(posedge i_clk_sys);
        exp_q.push_back(r);
    endtask
    task automatic wait_idle(input string nm);
        int n;
        n = 0;
        while ((exp_q.size() != 0 || active) && n < 400) begin
            @(posedge i_clk_sys);
            n++;
        end
        if (n == 400) begin
            cmp_pin("idle wait", 8'h1, 8'h0);
            tally_and_finish();
        end
        repeat (3) @(posedge i_clk_sys);
        $display("test %s done", nm);
    endtask
    task automatic tick_check();
        logic v;
        int   n;
        v = shift_clock_phase;
        n = 0;
        #1 i_pix_tick = 1'b1;
        @(posedge i_clk_sys);
        #1 i_pix_tick = 1'b0;
        while (pstb !== 1'b1 && n < 6) begin
            @(posedge i_clk_sys);
            #2;
            n++;
        end
        cmp_pin("tick strobe", 8'h1, {7'h0, pstb});
        cmp_pin("phase toggle", v ? 8'h0 : 8'h1, {7'h0, shift_clock_phase});
        @(posedge i_clk_sys);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        vtc_pkg::vtc_req_s r;
        i_reset = 1'b1;
        i_req_valid = 1'b0;
        i_req = '0;
        i_pix_tick = 1'b0;
        err_count = 0;
        tests_run = 0;
        active = 1'b0;
        saw_full = 1'b0;
        void'($urandom(32'h155fa7cf));
        repeat (5) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        cmp_pin("idle pins", 8'h1e, {o_mem.ras_n, o_mem.cas_n, o_mem.xfg_n, shift_clock_phase, pstb});
        cmp_pin("idle we_n", 8'h0f, o_mem.we_n);
        cmp_pin("idle ready busy", 8'h02, {o_req_ready, o_busy});
        $display("test reset done");
        @(posedge i_clk_sys);
        // every bank with extreme addresses, back to back
        for (int b = 0; b < 4; b++) begin
            r = rnd_req();
            r.bank = b[1:0];
            r.row = 8'hff;
            r.start = 8'h00;
            r.offset = 3'h7;
            r.bitcount = 3'h0;
            r.pulse_en = b[0];
            push(r);
        end
        #1 i_req_valid = 1'b0;
        wait_idle("corner banks");
        // queue overrun: the request fifo must refuse
        saw_full = 1'b0;
        repeat (6) push(rnd_req());
        #1 i_req_valid = 1'b0;
        wait_idle("fifo fill");
        cmp_pin("fifo refused", 8'h1, {7'h0, saw_full});
        // random requests with random gaps
        repeat (12) begin
            repeat ($urandom_range(0, 20)) @(posedge i_clk_sys);
            push(rnd_req());
            #1 i_req_valid = 1'b0;
        end
        wait_idle("random");
        // later pixel strobes, and no transfer without a request
        repeat (4) tick_check();
        repeat (40) @(posedge i_clk_sys);
        $display("test pixel ticks done");
        tally_and_finish();
    end
endmodule // vtc_transfer_test
`default_nettype wire

//--- test/vtc_vram_model.sv
`default_nettype none
// ****
// far side: video memory banks, board glue and four serializers
// ****
module vtc_vram_model (
    // design pins
    input  wire vtc_pkg::vtc_mem_s          i_mem,
    input  wire logic [vtc_pkg::CTL_W-1:0]  i_ctl,
    input  wire logic                       i_phase,
    input  wire logic                       i_strobe,
    // glue and serializer state
    output logic                            o_load_pulse,
    output logic [1:0]                      o_bank_q,
    output logic [11:0]                     o_offset_cap,
    output logic [2:0]                      o_bitcount_cap,
    output logic [3:0]                      o_right_clk,
    output logic [3:0]                      o_left_clk,
    output logic [3:0]                      o_right_en,
    output logic [3:0]                      o_left_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] sel;  // one-hot selected bank
    // glue flops start cleared
    initial begin
        o_load_pulse = 1'b0;
        o_bank_q = 2'h0;
        o_offset_cap = 12'h000;
        o_bitcount_cap = 3'h0;
    end
    // load pulse: inverted gate strobe taken at row fall, cleared at row rise
    always @(negedge i_mem.ras_n or posedge i_mem.ras_n) begin
        o_load_pulse = i_mem.ras_n ? 1'b0 : ~i_mem.xfg_n;
    end
    // bank bits latched and offset taken by all four serializers on pulse rise
    always @(posedge o_load_pulse) begin
        o_bank_q = i_mem.bank;
        o_offset_cap = {4{i_ctl}};
    end
    // serializers take the bit count on each pixel byte strobe
    always @(posedge i_strobe) begin
        o_bitcount_cap = i_ctl;
    end
    // per-bank decode of shift clock and serial enables
    assign sel = 4'h1 << o_bank_q;
    assign o_right_clk = sel & {4{i_phase}};
    assign o_left_clk = sel & {4{~i_phase}};
    assign o_right_en = sel & {4{~i_phase}};
    assign o_left_en = sel & {4{i_phase}};
endmodule // vtc_vram_model
`default_nettype wire
